// >>> hdl/ddr2_pkg.sv
// ddr2_pkg: constants, mode word layout, command codes and state carrier types
// assumes a single 100 MHz core clock and command pins that arrive asynchronous
//
// What this block does
// [R1] deselect or no-op registers nothing; running bursts and counters carry on
// [R2] load mode writes address bits into the register chosen by bank address; the block keeps only bank address 0 and ignores the rest
// [R3] activate opens the addressed row in the addressed bank until precharged
// [R4] controller precharges a bank before opening another row in it
// [R5] read starts a burst at the given column; A10 set precharges afterwards
// [R6] write starts a burst at the given column; A10 set precharges afterwards
// [R7] posted latency delays internal registration of read or write by that many clocks; settings above 6 are held at 6
// [R8] write beat with mask low is stored; mask high leaves the location unchanged
// [R9] precharge closes one or all banks; activation waits for the precharge period
// [R10] reads and writes to other banks are taken while a bank auto-precharges
// [R11] controller activates a precharged bank before reading or writing it
// [R12] precharge to idle or precharging bank restarts its precharge period
// [R13] refresh uses an internal row counter, ignores address, once per command
// [R14] refresh code with clock enable low enters self refresh
// [R15] delay loop is off in self refresh and back on, reset, on exit
// [R16] every load mode carries all fields; contents held until next load; with M7 high the block takes only the test bit
// [R17] mode bit M8 pulses the delay loop reset and clears itself
// [R18] bits M0-M2 give burst length four or eight for reads and writes
// [R19] burst stays in an aligned block of burst length and wraps at its edge
// [R20] bit M3 picks sequential or interleaved order within a burst
// [R21] interleave is start xor beat; sequential counts low bits within a nibble
// [R22] M7 low loads all fields; M7 high only enters test mode
// [R23] controller waits 200 clocks after a loop reset before any read
// [R24] bits M4-M6 give read latency three to seven whole clocks
// [R25] bits M9-M11 give write recovery two to eight clocks before auto precharge
// [R26] bit M12 picks fast or slow exit for active power-down only
// [R27] length code 010 is four, 011 is eight; type bit 0 sequential, 1 interleaved
package ddr2_pkg;

	// ------------------------------------------------------------
	// timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int T_RP_NS = 15;
	localparam int RP_CYCLES = (T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int CNT_W = 4;
	localparam logic [CNT_W-1:0] RP_CNT = CNT_W'(RP_CYCLES);
	localparam logic [CNT_W-1:0] WL_GAP = 4'h2;

	// ------------------------------------------------------------
	// widths and field positions
	// ------------------------------------------------------------
	localparam int BANKS = 8;
	localparam int BA_W = 3;
	localparam int ADDR_W = 14;
	localparam int ROW_W = 14;
	localparam int COL_W = 10;
	localparam int DQ_W = 8;
	localparam int PIPE_W = 8;
	localparam int AL_MAX = 6;
	localparam logic [2:0] AL_LIMIT = 3'(AL_MAX);
	localparam int AUTO_PRE_BIT = 10;
	localparam int TEST_BIT = 7;
	localparam int DLL_RST_BIT = 8;
	localparam logic [BA_W-1:0] MODE_SEL_MAIN = 3'h0;
	localparam logic [2:0] BL_CODE_4 = 3'h2;
	localparam logic [2:0] BL_CODE_8 = 3'h3;
	localparam logic [2:0] LAST_BEAT_4 = 3'h3;
	localparam logic [2:0] LAST_BEAT_8 = 3'h7;
	localparam logic BT_INTERLEAVE = 1'b1;

	// ------------------------------------------------------------
	// command codes on ras_n, cas_n, we_n
	// ------------------------------------------------------------
	localparam logic [2:0] CODE_NOP = 3'h7;
	localparam logic [2:0] CODE_MODE = 3'h0;
	localparam logic [2:0] CODE_ACT = 3'h3;
	localparam logic [2:0] CODE_RD = 3'h5;
	localparam logic [2:0] CODE_WR = 3'h4;
	localparam logic [2:0] CODE_PRE = 3'h2;
	localparam logic [2:0] CODE_REF = 3'h1;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef struct packed {
		logic [3:0] rsvd;
		logic slow_pd;
		logic [2:0] wr;
		logic dll_rst;
		logic test;
		logic [2:0] cl;
		logic bt;
		logic [2:0] bl;
	} mode_t;

	localparam mode_t MODE_RESET = 17'h00000;

	typedef enum logic [7:0] {
		CMD_NOP = 8'h01,
		CMD_MODE = 8'h02,
		CMD_ACT = 8'h04,
		CMD_RD = 8'h08,
		CMD_WR = 8'h10,
		CMD_PRE = 8'h20,
		CMD_REF = 8'h40,
		CMD_SREF = 8'h80
	} cmd_t;

	typedef enum logic [3:0] {
		PH_IDLE = 4'h1,
		PH_WAIT = 4'h2,
		PH_BEAT = 4'h4,
		PH_RECOVER = 4'h8
	} phase_t;

	typedef struct packed {
		logic cs_n;
		logic ras_n;
		logic cas_n;
		logic we_n;
		logic cke;
		logic [BA_W-1:0] ba;
		logic [ADDR_W-1:0] addr;
		logic dm;
		logic [DQ_W-1:0] dq;
	} pins_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic auto_pre;
		logic [BA_W-1:0] ba;
		logic [COL_W-1:0] col;
	} pend_t;

	typedef struct packed {
		pins_t s1;
		pins_t s2;
		phase_t phase;
		logic self_ref;
		logic dll_on;
		mode_t mode;
		logic [BANKS-1:0] open;
		logic [BANKS-1:0][ROW_W-1:0] row;
		logic [BANKS-1:0][CNT_W-1:0] rp_cnt;
		pend_t [AL_MAX-1:0] pend;
		logic b_write;
		logic b_auto;
		logic [BA_W-1:0] b_ba;
		logic [COL_W-1:0] b_col;
		logic [2:0] b_beat;
		logic [CNT_W-1:0] wait_cnt;
		logic [PIPE_W-1:0] rd_pipe;
		logic rd;
		logic wr;
		logic rd_valid;
		logic refresh;
		logic dll_reset;
		logic [BA_W-1:0] arr_bank;
		logic [ROW_W-1:0] arr_row;
		logic [COL_W-1:0] arr_col;
		logic [DQ_W-1:0] wdata;
		logic [ROW_W-1:0] ref_row;
	} state_t;

endpackage

// >>> hdl/burst_order.sv
// burst_order: column offset of one beat inside the burst block
// assumes start and beat are stable in the cycle they are used; purely combinational
`timescale 1ns/1ps
module burst_order (
	input wire logic [2:0] i_start,
	input wire logic [2:0] i_beat,
	input wire logic i_len8,
	input wire logic i_interleave,
	output logic [2:0] o_offset
);

	// ------------------------------------------------------------
	// order
	// ------------------------------------------------------------
	logic [1:0] low;
	logic high;

	always_comb begin
		if (i_interleave) begin
			low = i_start[1:0] ^ i_beat[1:0]; // [R21]
		end else begin
			low = i_start[1:0] + i_beat[1:0]; // [R21]
		end
		// length four keeps A2 fixed, so the block never leaves its quad
		high = i_len8 ? (i_start[2] ^ i_beat[2]) : i_start[2]; // [R19]
		o_offset = {high, low};
	end

endmodule

// >>> hdl/ddr2_cmd_mode.sv
// ddr2_cmd_mode: command decoder, bank tracker, burst engine and mode word
// assumes the controller keeps its own ordering and timing duties; pins are async
`timescale 1ns/1ps
module ddr2_cmd_mode (
	input wire logic i_core_clk,
	input wire logic i_rst_n,
	input wire logic i_cs_n,
	input wire logic i_ras_n,
	input wire logic i_cas_n,
	input wire logic i_we_n,
	input wire logic i_cke,
	input wire logic [ddr2_pkg::BA_W-1:0] i_ba,
	input wire logic [ddr2_pkg::ADDR_W-1:0] i_addr,
	input wire logic i_dm,
	input wire logic [ddr2_pkg::DQ_W-1:0] i_dq,
	input wire logic [2:0] i_posted_added_latency,
	output logic o_array_rd,
	output logic o_array_wr,
	output logic [ddr2_pkg::BA_W-1:0] o_array_bank,
	output logic [ddr2_pkg::ROW_W-1:0] o_array_row,
	output logic [ddr2_pkg::COL_W-1:0] o_array_col,
	output logic [ddr2_pkg::DQ_W-1:0] o_array_wdata,
	output logic o_rd_valid,
	output logic o_refresh,
	output logic [ddr2_pkg::ROW_W-1:0] o_refresh_row,
	output logic o_self_refresh,
	output logic o_dll_on,
	output logic o_dll_reset,
	output logic o_slow_exit_pd,
	output logic o_test_mode,
	output logic [ddr2_pkg::BANKS-1:0] o_bank_open,
	output ddr2_pkg::mode_t o_mode
);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	ddr2_pkg::state_t st;
	ddr2_pkg::state_t nx;
	ddr2_pkg::pins_t pin_now;
	ddr2_pkg::cmd_t cmd;
	ddr2_pkg::pend_t direct;
	ddr2_pkg::pend_t fire;
	logic [2:0] al;
	logic [2:0] ord_start;
	logic [2:0] ord_beat;
	logic [2:0] ord_off;
	logic [2:0] last_beat;
	logic [ddr2_pkg::CNT_W-1:0] wr_clocks;
	logic len8;

	// ------------------------------------------------------------
	// decode helpers
	// ------------------------------------------------------------
	function automatic ddr2_pkg::cmd_t decode(input ddr2_pkg::pins_t p);
		if (p.cs_n) begin
			return ddr2_pkg::CMD_NOP; // [R1]
		end
		unique case ({p.ras_n, p.cas_n, p.we_n})
			ddr2_pkg::CODE_NOP: return ddr2_pkg::CMD_NOP; // [R1]
			ddr2_pkg::CODE_MODE: return ddr2_pkg::CMD_MODE;
			ddr2_pkg::CODE_ACT: return ddr2_pkg::CMD_ACT;
			ddr2_pkg::CODE_RD: return ddr2_pkg::CMD_RD;
			ddr2_pkg::CODE_WR: return ddr2_pkg::CMD_WR;
			ddr2_pkg::CODE_PRE: return ddr2_pkg::CMD_PRE;
			ddr2_pkg::CODE_REF: return p.cke ? ddr2_pkg::CMD_REF : ddr2_pkg::CMD_SREF; // [R14]
			default: return ddr2_pkg::CMD_NOP;
		endcase
	endfunction

	function automatic ddr2_pkg::state_t close_bank(
		input ddr2_pkg::state_t s,
		input logic [ddr2_pkg::BA_W-1:0] ba,
		input logic all
	);
		ddr2_pkg::state_t r;
		r = s;
		for (int i = 0; i < ddr2_pkg::BANKS; i++) begin
			if (all || ba == ddr2_pkg::BA_W'(i)) begin
				r.open[i] = 1'b0; // [R9]
				// a repeat precharge simply restarts the count
				r.rp_cnt[i] = ddr2_pkg::RP_CNT; // [R12]
			end
		end
		return r;
	endfunction

	// ------------------------------------------------------------
	// combinational views
	// ------------------------------------------------------------
	assign pin_now = '{
		cs_n: i_cs_n,
		ras_n: i_ras_n,
		cas_n: i_cas_n,
		we_n: i_we_n,
		cke: i_cke,
		ba: i_ba,
		addr: i_addr,
		dm: i_dm,
		dq: i_dq
	};

	assign cmd = st.self_ref ? ddr2_pkg::CMD_NOP : decode(st.s2);
	assign al = (i_posted_added_latency > ddr2_pkg::AL_LIMIT) ? ddr2_pkg::AL_LIMIT
		: i_posted_added_latency;
	assign len8 = (st.mode.bl == ddr2_pkg::BL_CODE_8); // [R27]
	assign last_beat = len8 ? ddr2_pkg::LAST_BEAT_8 : ddr2_pkg::LAST_BEAT_4; // [R18]
	assign wr_clocks = {1'b0, st.mode.wr} + 4'h1; // [R25]

	assign direct = '{
		valid: (cmd == ddr2_pkg::CMD_RD) || (cmd == ddr2_pkg::CMD_WR),
		write: (cmd == ddr2_pkg::CMD_WR),
		auto_pre: st.s2.addr[ddr2_pkg::AUTO_PRE_BIT],
		ba: st.s2.ba,
		col: st.s2.addr[ddr2_pkg::COL_W-1:0]
	};
	// posted commands come out of the delay line, immediate ones straight in
	assign fire = (al == 3'h0) ? direct : st.pend[0]; // [R7]

	assign ord_start = fire.valid ? fire.col[2:0] : st.b_col[2:0];
	assign ord_beat = fire.valid ? 3'h0 : st.b_beat;

	burst_order u_order (
		.i_start(ord_start),
		.i_beat(ord_beat),
		.i_len8(len8),
		.i_interleave(st.mode.bt == ddr2_pkg::BT_INTERLEAVE), // [R20]
		.o_offset(ord_off)
	);

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		nx = st;
		nx.s1 = pin_now;
		nx.s2 = st.s1;
		nx.rd = 1'b0;
		nx.wr = 1'b0;
		nx.refresh = 1'b0;
		nx.dll_reset = 1'b0;
		nx.mode.dll_rst = 1'b0; // [R17]
		nx.rd_valid = st.rd_pipe[st.mode.cl - 3'h1]; // [R24]
		for (int i = 0; i < ddr2_pkg::BANKS; i++) begin
			if (st.rp_cnt[i] != '0) begin
				nx.rp_cnt[i] = st.rp_cnt[i] - 4'h1;
			end
		end
		for (int i = 0; i < ddr2_pkg::AL_MAX - 1; i++) begin
			nx.pend[i] = st.pend[i + 1];
		end
		nx.pend[ddr2_pkg::AL_MAX - 1] = '0;

		// commands
		if (st.self_ref) begin
			if (st.s2.cke) begin
				nx.self_ref = 1'b0;
				nx.dll_on = 1'b1; // [R15]
				nx.dll_reset = 1'b1; // [R15]
			end
		end else begin
			unique case (cmd)
				ddr2_pkg::CMD_NOP: begin
				end
				ddr2_pkg::CMD_MODE: begin
					if (st.s2.ba == ddr2_pkg::MODE_SEL_MAIN) begin
						if (st.s2.addr[ddr2_pkg::TEST_BIT]) begin
							nx.mode.test = 1'b1; // [R22]
						end else begin
							// the whole word is taken every time
							nx.mode = ddr2_pkg::mode_t'({st.s2.ba, st.s2.addr}); // [R2] [R16]
							nx.dll_reset = st.s2.addr[ddr2_pkg::DLL_RST_BIT]; // [R17]
						end
					end
				end
				ddr2_pkg::CMD_ACT: begin
					if (!st.open[st.s2.ba] && st.rp_cnt[st.s2.ba] == '0) begin
						nx.open[st.s2.ba] = 1'b1; // [R3] [R9]
						nx.row[st.s2.ba] = st.s2.addr[ddr2_pkg::ROW_W-1:0]; // [R3]
					end
				end
				ddr2_pkg::CMD_RD, ddr2_pkg::CMD_WR: begin
					if (al != 3'h0) begin
						nx.pend[al - 3'h1] = direct; // [R7]
					end
				end
				ddr2_pkg::CMD_PRE: begin
					nx = close_bank(nx, st.s2.ba, st.s2.addr[ddr2_pkg::AUTO_PRE_BIT]); // [R9]
				end
				ddr2_pkg::CMD_REF: begin
					if (st.open == '0) begin
						nx.refresh = 1'b1; // [R13]
						nx.ref_row = st.ref_row + 14'h0001; // [R13]
					end
				end
				ddr2_pkg::CMD_SREF: begin
					if (st.open == '0) begin
						nx.self_ref = 1'b1; // [R14]
						nx.dll_on = 1'b0; // [R15]
					end
				end
			endcase
		end

		// burst engine; other banks may start while one recovers
		if (fire.valid) begin
			if (st.phase == ddr2_pkg::PH_RECOVER) begin
				// new burst must not lose the pending close; lockout covers the rest of recovery
				nx = close_bank(nx, st.b_ba, 1'b0); // [R6] [R10]
				nx.rp_cnt[st.b_ba] = st.wait_cnt + ddr2_pkg::RP_CNT; // [R10]
			end
			nx.b_write = fire.write;
			nx.b_auto = fire.auto_pre; // [R5] [R6]
			nx.b_ba = fire.ba;
			nx.b_col = fire.col;
			nx.arr_bank = fire.ba;
			nx.arr_row = st.row[fire.ba];
			if (fire.write) begin
				nx.phase = ddr2_pkg::PH_WAIT;
				nx.wait_cnt = {1'b0, st.mode.cl} - ddr2_pkg::WL_GAP;
				nx.b_beat = 3'h0;
			end else begin
				nx.rd = 1'b1; // [R5]
				nx.arr_col = {fire.col[ddr2_pkg::COL_W-1:3], ord_off}; // [R19]
				nx.b_beat = 3'h1;
				nx.phase = ddr2_pkg::PH_BEAT;
			end
		end else begin
			unique case (st.phase)
				ddr2_pkg::PH_IDLE: begin
				end
				ddr2_pkg::PH_WAIT: begin
					if (st.wait_cnt == '0) begin
						nx.phase = ddr2_pkg::PH_BEAT;
					end else begin
						nx.wait_cnt = st.wait_cnt - 4'h1;
					end
				end
				ddr2_pkg::PH_BEAT: begin
					nx.arr_col = {st.b_col[ddr2_pkg::COL_W-1:3], ord_off}; // [R19] [R21]
					if (st.b_write) begin
						nx.wr = !st.s2.dm; // [R8]
						nx.wdata = st.s2.dq;
					end else begin
						nx.rd = 1'b1;
					end
					nx.b_beat = st.b_beat + 3'h1;
					if (st.b_beat == last_beat) begin
						if (!st.b_auto) begin
							nx.phase = ddr2_pkg::PH_IDLE; // [R5] [R6]
						end else if (st.b_write) begin
							nx.phase = ddr2_pkg::PH_RECOVER;
							nx.wait_cnt = wr_clocks; // [R25]
						end else begin
							nx = close_bank(nx, st.b_ba, 1'b0); // [R5] [R10]
							nx.phase = ddr2_pkg::PH_IDLE;
						end
					end
				end
				ddr2_pkg::PH_RECOVER: begin
					if (st.wait_cnt == 4'h1) begin
						nx = close_bank(nx, st.b_ba, 1'b0); // [R6] [R25]
						nx.phase = ddr2_pkg::PH_IDLE;
					end else begin
						nx.wait_cnt = st.wait_cnt - 4'h1;
					end
				end
			endcase
		end
		nx.rd_pipe = {st.rd_pipe[ddr2_pkg::PIPE_W-2:0], nx.rd}; // [R24]
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			st <= '0;
			st.phase <= ddr2_pkg::PH_IDLE;
			// synchroniser idles deselected, else all-zero pins decode as a load mode
			st.s1.cs_n <= 1'b1;
			st.s2.cs_n <= 1'b1;
			st.s1.cke <= 1'b1;
			st.s2.cke <= 1'b1;
			st.dll_on <= 1'b1;
			st.mode <= ddr2_pkg::MODE_RESET;
		end else begin
			st <= nx;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign o_array_rd = st.rd;
	assign o_array_wr = st.wr;
	assign o_array_bank = st.arr_bank;
	assign o_array_row = st.arr_row;
	assign o_array_col = st.arr_col;
	assign o_array_wdata = st.wdata;
	assign o_rd_valid = st.rd_valid;
	assign o_refresh = st.refresh;
	assign o_refresh_row = st.ref_row;
	assign o_self_refresh = st.self_ref;
	assign o_dll_on = st.dll_on;
	assign o_dll_reset = st.dll_reset;
	// power-down exit choice is only reported; entry lives elsewhere
	assign o_slow_exit_pd = st.mode.slow_pd; // [R26]
	assign o_test_mode = st.mode.test;
	assign o_bank_open = st.open;
	assign o_mode = st.mode;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_n);

	property p_nop_holds;
		(cmd == ddr2_pkg::CMD_NOP && st.phase == ddr2_pkg::PH_IDLE && !fire.valid)
			|=> $stable(st.open) && (st.mode[ddr2_pkg::TEST_BIT:0] == $past(st.mode[7:0]));
	endproperty
	a_nop_holds: assert property (p_nop_holds) else $error("nop changed state"); // [R1]

	property p_mode_load;
		(cmd == ddr2_pkg::CMD_MODE && st.s2.ba == 3'h0 && !st.s2.addr[7])
			|=> (st.mode.bl == $past(st.s2.addr[2:0])) && (st.mode.cl == $past(st.s2.addr[6:4]));
	endproperty
	a_mode_load: assert property (p_mode_load) else $error("mode word not loaded"); // [R2]

	property p_activate;
		(cmd == ddr2_pkg::CMD_ACT && !st.open[st.s2.ba] && st.rp_cnt[st.s2.ba] == 4'h0)
			|=> st.open[$past(st.s2.ba)] && (st.row[$past(st.s2.ba)] == $past(st.s2.addr));
	endproperty
	a_activate: assert property (p_activate) else $error("row not opened"); // [R3]

	property p_precharge;
		(cmd == ddr2_pkg::CMD_PRE && st.s2.addr[10])
			|=> (st.open == 8'h00) ##1 (st.open == 8'h00);
	endproperty
	a_precharge: assert property (p_precharge) else $error("precharge all failed"); // [R9]

	property p_read_len8;
		(direct.valid && !direct.write && al == 3'h0 && len8) |=> o_array_rd [*8] ##1 !o_array_rd;
	endproperty
	a_read_len8: assert property (p_read_len8) else $error("burst of eight wrong"); // [R18]

	property p_latency3;
		(direct.valid && !direct.write && al == 3'h0 && st.mode.cl == 3'h3) |-> ##4 o_rd_valid;
	endproperty
	a_latency3: assert property (p_latency3) else $error("read latency wrong"); // [R24]

	property p_posted2;
		(direct.valid && !direct.write && al == 3'h2) |=> !o_array_rd ##2 o_array_rd;
	endproperty
	a_posted2: assert property (p_posted2) else $error("posted read timing wrong"); // [R7]

	property p_sref;
		(cmd == ddr2_pkg::CMD_SREF && st.open == 8'h00) |=> o_self_refresh && !o_dll_on;
	endproperty
	a_sref: assert property (p_sref) else $error("self refresh entry wrong"); // [R14]

	property p_dll_self_clear;
		st.mode.dll_rst |=> !st.mode.dll_rst && $past(o_dll_reset);
	endproperty
	a_dll_self_clear: assert property (p_dll_self_clear) else $error("M8 stuck"); // [R17]

	property p_refresh;
		(cmd == ddr2_pkg::CMD_REF && st.open == 8'h00)
			|=> o_refresh && (o_refresh_row == $past(o_refresh_row) + 14'h0001);
	endproperty
	a_refresh: assert property (p_refresh) else $error("refresh step wrong"); // [R13]

	property p_mask;
		(st.phase == ddr2_pkg::PH_BEAT && st.b_write && !fire.valid)
			|=> (o_array_wr == !$past(st.s2.dm));
	endproperty
	a_mask: assert property (p_mask) else $error("data mask ignored"); // [R8]

endmodule

// >>> dv/ddr2_ctrl_model.sv
// ddr2_ctrl_model: controller side, drives command, mask and data pins
// assumes the bench calls its tasks one at a time from one process
`timescale 1ns/1ps
module ddr2_ctrl_model (
	input wire logic i_core_clk,
	output ddr2_pkg::pins_t o_pins
);
	// ------
	// state
	// ------
	localparam int MRD = 2;
	logic [7:0] open = 8'h00;
	logic ck = 1'b1;
	int cyc = 0;
	int dll_at = -1000;

	initial begin
		o_pins = '0;
		o_pins.cs_n = 1'b1;
		o_pins.cke = 1'b1;
		o_pins.dm = 1'b1;
	end

	always @(posedge i_core_clk) begin
		cyc <= cyc + 1;
	end

	// ------
	// one command then a no-op; cke keeps its last level
	// ------
	task automatic cmd(input logic [2:0] code, input logic [2:0] ba, input logic [13:0] a);
		@(posedge i_core_clk);
		o_pins.cs_n <= 1'b0;
		{o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= code;
		o_pins.cke <= ck;
		o_pins.ba <= ba;
		o_pins.addr <= a;
		@(posedge i_core_clk);
		{o_pins.ras_n, o_pins.cas_n, o_pins.we_n} <= ddr2_pkg::CODE_NOP;
		// released lines must not keep the last value
		o_pins.ba <= ~ba;
		o_pins.addr <= ~a;
	endtask

	task automatic pre_all();
		if (|open) cmd(ddr2_pkg::CODE_PRE, 3'h0, 14'h0400);
		open = 8'h00;
		repeat (4) @(posedge i_core_clk);
	endtask

	task automatic mode(input ddr2_pkg::mode_t m);
		pre_all();
		m.test = 1'b0;
		cmd(ddr2_pkg::CODE_MODE, m[16:14], m[13:0]);
		if (m.dll_rst) dll_at = cyc;
		repeat (MRD) @(posedge i_core_clk);
	endtask

	task automatic act(input logic [2:0] ba, input logic [13:0] row);
		if (open[ba]) begin
			cmd(ddr2_pkg::CODE_PRE, ba, 14'h0000);
			repeat (4) @(posedge i_core_clk);
		end
		cmd(ddr2_pkg::CODE_ACT, ba, row);
		open[ba] = 1'b1;
	endtask

	task automatic rd(input logic [2:0] ba, input logic [9:0] col, input logic ap);
		if (!open[ba]) act(ba, 14'h0001);
		while (cyc < dll_at + 200) @(posedge i_core_clk);
		cmd(ddr2_pkg::CODE_RD, ba, {3'h0, ap, col});
		if (ap) open[ba] = 1'b0;
	endtask

	task automatic wr(input logic [2:0] ba, input logic [9:0] col, input logic ap, input int cl,
		input logic [31:0] d, input logic [3:0] dm);
		if (!open[ba]) act(ba, 14'h0001);
		cmd(ddr2_pkg::CODE_WR, ba, {3'h0, ap, col});
		if (ap) open[ba] = 1'b0;
		repeat (cl - 1) @(posedge i_core_clk);
		for (int j = 0; j < 4; j++) begin
			if (j > 0) @(posedge i_core_clk);
			o_pins.dq <= d[8*j +: 8];
			o_pins.dm <= dm[j];
		end
		@(posedge i_core_clk);
		o_pins.dq <= ~d[31:24];
		o_pins.dm <= 1'b1;
	endtask

	task automatic refresh(input logic cke_level);
		pre_all();
		ck = cke_level;
		cmd(ddr2_pkg::CODE_REF, 3'h5, 14'h2AAA);
	endtask

	task automatic sref_exit();
		ck = 1'b1;
		@(posedge i_core_clk);
		o_pins.cke <= 1'b1;
		dll_at = cyc; // loop restarts on exit
	endtask
endmodule

// >>> dv/tb.sv
// tb: bench top for the command and mode logic
// assumes all pin traffic goes through the controller model tasks
`timescale 1ns/1ps
module tb;
	logic clk;
	logic i_rst_n;
	logic [2:0] al;
	ddr2_pkg::pins_t p;
	logic ard, awr, rdv, rf, sr, don, drst, spd, tm;
	logic [2:0] abank;
	logic [13:0] arow, rrow;
	logic [9:0] acol;
	logic [7:0] awd, bopen;
	ddr2_pkg::mode_t mo, m;
	int err_count, check_count, cyc, t0, lat0, drc;
	int rc[$], vc[$], fr[$];
	logic [9:0] cq[$];
	logic [7:0] wq[$];

	ddr2_ctrl_model ctrl (.i_core_clk(clk), .o_pins(p));
	ddr2_cmd_mode DUT (.i_core_clk(clk), .i_rst_n(i_rst_n), .i_cs_n(p.cs_n), .i_ras_n(p.ras_n),
		.i_cas_n(p.cas_n), .i_we_n(p.we_n), .i_cke(p.cke), .i_ba(p.ba), .i_addr(p.addr),
		.i_dm(p.dm), .i_dq(p.dq), .i_posted_added_latency(al), .o_array_rd(ard),
		.o_array_wr(awr), .o_array_bank(abank), .o_array_row(arow), .o_array_col(acol),
		.o_array_wdata(awd), .o_rd_valid(rdv), .o_refresh(rf), .o_refresh_row(rrow),
		.o_self_refresh(sr), .o_dll_on(don), .o_dll_reset(drst), .o_slow_exit_pd(spd),
		.o_test_mode(tm), .o_bank_open(bopen), .o_mode(mo));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ------
	// monitor
	// ------
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (ard) begin
			rc.push_back(cyc);
			cq.push_back(acol);
		end
		if (awr) wq.push_back(awd);
		if (rdv) vc.push_back(cyc);
		if (rf) fr.push_back(int'(rrow));
		if (drst) drc <= drc + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	function automatic ddr2_pkg::mode_t mw(input logic bl8, input logic bt, input logic dr);
		mw = ddr2_pkg::MODE_RESET;
		mw.bl = bl8 ? ddr2_pkg::BL_CODE_8 : ddr2_pkg::BL_CODE_4;
		mw.bt = bt;
		mw.cl = 3'h3;
		mw.dll_rst = dr;
		mw.wr = 3'h2;
		mw.slow_pd = 1'b1;
	endfunction

	// read burst, order worked out from start column and beat index
	task automatic burst(input logic [2:0] ba, input logic [9:0] col, input logic ap,
		input logic bl8, input logic bt);
		int n;
		logic [2:0] o;
		rc.delete();
		cq.delete();
		vc.delete();
		n = bl8 ? 8 : 4;
		ctrl.rd(ba, col, ap);
		t0 = cyc;
		repeat (24) @(posedge clk);
		chk(rc.size(), n);
		chk(vc.size(), n);
		for (int j = 0; j < n; j++) begin
			o = bt ? col[2:0] ^ 3'(j) : {col[2] ^ (j > 3), col[1:0] + 2'(j)};
			chk(cq[j], {col[9:3], o});
			chk(rc[j] - rc[0], j);
			chk(vc[j] - rc[j], 3);
		end
		chk(arow, 14'h0001);
		chk(abank, ba);
		chk(bopen[ba], !ap);
	endtask

	initial begin
		#200000;
		err_count++;
		report_and_stop();
	end

	initial begin
		i_rst_n = 1'b0;
		al = 3'h0;
		err_count = 0;
		check_count = 0;
		cyc = 0;
		drc = 0;
		repeat (16) @(posedge clk);
		i_rst_n <= 1'b1;
		@(posedge clk);
		chk(mo, ddr2_pkg::MODE_RESET);
		chk({don, bopen}, 9'h100);
		$display("test reset done");
		m = mw(1'b0, 1'b0, 1'b1);
		ctrl.mode(m);
		repeat (4) @(posedge clk);
		m.dll_rst = 1'b0;
		chk(mo, m);
		chk(drc, 1);
		chk({spd, tm}, 2'b10);
		ctrl.cmd(ddr2_pkg::CODE_MODE, 3'h1, 14'h0FFF);
		repeat (4) @(posedge clk);
		chk(mo, m);
		ctrl.cmd(ddr2_pkg::CODE_MODE, 3'h0, 14'h1F80);
		repeat (4) @(posedge clk);
		m.test = 1'b1;
		chk({tm, mo}, {1'b1, m});
		$display("test mode load done");
		for (int i = 0; i < 4; i++) begin
			ctrl.mode(mw(i[1], i[0], 1'b0));
			burst(3'h2, 10'h2A5, i[0], i[1], i[0]);
		end
		$display("test burst order done");
		lat0 = rc[0] - t0;
		al <= 3'h2;
		burst(3'h2, 10'h2A5, 1'b1, 1'b1, 1'b1);
		chk(rc[0] - t0 - lat0, 2);
		al <= 3'h0;
		$display("test posted latency done");
		ctrl.mode(mw(1'b0, 1'b0, 1'b0));
		wq.delete();
		ctrl.act(3'h4, 14'h0001);
		ctrl.wr(3'h1, 10'h012, 1'b1, 3, 32'hD4C3B2A1, 4'b0010);
		burst(3'h4, 10'h010, 1'b0, 1'b0, 1'b0);
		chk(wq.size(), 3);
		chk({wq[0], wq[1], wq[2]}, 24'hA1C3D4);
		chk(bopen[1], 1'b0);
		$display("test masked write done");
		ctrl.act(3'h3, 14'h0155);
		ctrl.cmd(ddr2_pkg::CODE_PRE, 3'h3, 14'h0000);
		ctrl.cmd(ddr2_pkg::CODE_PRE, 3'h3, 14'h0000);
		ctrl.cmd(ddr2_pkg::CODE_ACT, 3'h3, 14'h0155);
		repeat (4) @(posedge clk);
		chk(bopen[3], 1'b0);
		ctrl.cmd(ddr2_pkg::CODE_ACT, 3'h3, 14'h0155);
		repeat (4) @(posedge clk);
		chk(bopen[3], 1'b1);
		ctrl.pre_all();
		chk(bopen, 8'h00);
		$display("test precharge done");
		fr.delete();
		ctrl.refresh(1'b1);
		ctrl.refresh(1'b1);
		repeat (4) @(posedge clk);
		chk(fr.size(), 2);
		chk(fr[1] - fr[0], 1);
		$display("test refresh done");
		ctrl.refresh(1'b0);
		repeat (4) @(posedge clk);
		chk({sr, don}, 2'b10);
		ctrl.sref_exit();
		repeat (6) @(posedge clk);
		chk({sr, don}, 2'b01);
		chk(drc, 2);
		$display("test self refresh done");
		report_and_stop();
	end
endmodule
